// >>> design/vsis_pkg.sv
package vsis_pkg;

    // Register byte offsets on the APB bus.
    localparam logic [7:0] VSIS_CTRL_OFS = 8'h00;
    localparam logic [7:0] VSIS_STATUS_OFS = 8'h04;

    // Control register fields.
    localparam int VSIS_CTRL_FIELD_LOCK_BIT = 0;
    localparam int VSIS_CTRL_LINE_LOCK_BIT = 1;
    localparam logic [1:0] VSIS_CTRL_RST = 2'h0;

    // Status register fields.
    localparam int VSIS_STAT_DRIVE_BIT = 0;
    localparam int VSIS_STAT_MODE_LSB = 1;
    localparam int VSIS_STAT_VLOCK_BIT = 4;
    localparam int VSIS_STAT_HLOCK_BIT = 5;
    localparam int VSIS_STAT_STRAP_BIT = 6;

    // Values after reset.
    localparam logic [2:0] VSIS_HOST_MODE_RST = 3'h0;
    localparam logic [1:0] VSIS_SYNC_RST = 2'h0;
    localparam logic [31:0] VSIS_PRDATA_RST = 32'h0000_0000;

    typedef struct packed {
        logic activeVideo;
        logic hsync;
        logic vsync;
        logic fieldOdd;
        logic verticalLocked;
        logic lineNoninverted;
        logic horizontalLocked;
        logic [9:0] luma;
        logic [9:0] chroma;
    } vsis_video_t;

    typedef struct packed {
        logic [1:0] syncAv;
        logic [1:0] syncFld;
        logic [1:0] syncLine;
        logic [1:0] syncLock;
        logic [1:0] syncRst;
        logic strapPhase;
        logic driveEn;
        logic [2:0] hostMode;
        logic [1:0] ctrl;
        vsis_video_t vidOut;
        logic fieldOut;
        logic lineOut;
        logic lockCtrlOut;
        logic resetOut;
        logic [31:0] prdata;
        logic pslverr;
    } vsis_state_t;

endpackage

// >>> design/vsis_sync_indicator.sv
`timescale 1ns/1ps

module vsis_sync_indicator
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire vsis_pkg::vsis_video_t vidIn,
    input wire logic lockControlIn,
    input wire logic resetInN,
    output logic resetOutN,
    input wire logic activeVideoFlagIn,
    output logic activeVideoFlagOut,
    output logic activeVideoFlagOe,
    input wire logic fieldFlagIn,
    output logic fieldFlagOut,
    output logic fieldFlagOe,
    input wire logic linePhaseFlagIn,
    output logic linePhaseFlagOut,
    output logic linePhaseFlagOe,
    input wire logic lockControlOutIn,
    output logic lockControlOutOut,
    output logic lockControlOutOe,
    output logic horizontalSyncOut,
    output logic horizontalSyncOe,
    output logic verticalSyncOut,
    output logic verticalSyncOe,
    output logic [9:0] lumaBusOut,
    output logic lumaBusOe,
    output logic [9:0] chromaBusOut,
    output logic chromaBusOe,
    output logic [2:0] hostMode
);
    import vsis_pkg::*;

    vsis_state_t s_reg;
    vsis_state_t s_next;
    logic setup;
    logic access;
    logic mapped;
    logic videoDrive;
    logic [31:0] statusWord;

    assign setup = psel && !penable;
    assign access = psel && penable;
    assign mapped = (paddr == VSIS_CTRL_OFS) || (paddr == VSIS_STATUS_OFS);
    // Video pins are driven only after reset and only if the strap asked for it.
    assign videoDrive = s_reg.driveEn && !s_reg.strapPhase;

    always_comb
    begin
        statusWord = 32'h0000_0000;
        statusWord[VSIS_STAT_DRIVE_BIT] = s_reg.driveEn;
        statusWord[VSIS_STAT_MODE_LSB +: 3] = s_reg.hostMode;
        statusWord[VSIS_STAT_VLOCK_BIT] = vidIn.verticalLocked;
        statusWord[VSIS_STAT_HLOCK_BIT] = vidIn.horizontalLocked;
        statusWord[VSIS_STAT_STRAP_BIT] = s_reg.strapPhase;
    end

    always_comb
    begin
        s_next = s_reg;
        s_next.syncAv = {s_reg.syncAv[0], activeVideoFlagIn};
        s_next.syncFld = {s_reg.syncFld[0], fieldFlagIn};
        s_next.syncLine = {s_reg.syncLine[0], linePhaseFlagIn};
        s_next.syncLock = {s_reg.syncLock[0], lockControlOutIn};
        s_next.syncRst = {s_reg.syncRst[0], resetInN};
        s_next.resetOut = s_reg.syncRst[1];
        s_next.strapPhase = !s_reg.syncRst[1];
        if (s_reg.strapPhase)
        begin
            // Straps are re-sampled every cycle of reset; the last sample is kept.
            s_next.driveEn = s_reg.syncAv[1];
            s_next.hostMode = {s_reg.syncFld[1], s_reg.syncLine[1], s_reg.syncLock[1]};
        end
        s_next.vidOut = vidIn;
        if (s_reg.ctrl[VSIS_CTRL_FIELD_LOCK_BIT])
        begin
            s_next.fieldOut = vidIn.verticalLocked;
        end
        else
        begin
            s_next.fieldOut = vidIn.fieldOdd;
        end
        if (s_reg.ctrl[VSIS_CTRL_LINE_LOCK_BIT])
        begin
            s_next.lineOut = vidIn.horizontalLocked;
        end
        else
        begin
            s_next.lineOut = vidIn.lineNoninverted;
        end
        s_next.lockCtrlOut = lockControlIn;
        if (setup)
        begin
            s_next.pslverr = !mapped;
            if (paddr == VSIS_CTRL_OFS)
            begin
                s_next.prdata = {30'h0000_0000, s_reg.ctrl};
            end
            else if (paddr == VSIS_STATUS_OFS)
            begin
                s_next.prdata = statusWord;
            end
            else
            begin
                s_next.prdata = 32'h0000_0000;
            end
        end
        if (access && pwrite && paddr == VSIS_CTRL_OFS)
        begin
            s_next.ctrl = pwdata[1:0];
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            s_reg.syncAv <= VSIS_SYNC_RST;
            s_reg.syncFld <= VSIS_SYNC_RST;
            s_reg.syncLine <= VSIS_SYNC_RST;
            s_reg.syncLock <= VSIS_SYNC_RST;
            s_reg.syncRst <= VSIS_SYNC_RST;
            s_reg.strapPhase <= 1'b1;
            s_reg.driveEn <= 1'b0;
            s_reg.hostMode <= VSIS_HOST_MODE_RST;
            s_reg.ctrl <= VSIS_CTRL_RST;
            s_reg.vidOut <= '0;
            s_reg.fieldOut <= 1'b0;
            s_reg.lineOut <= 1'b0;
            s_reg.lockCtrlOut <= 1'b0;
            s_reg.resetOut <= 1'b0;
            s_reg.prdata <= VSIS_PRDATA_RST;
            s_reg.pslverr <= 1'b0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign pready = access;
    assign pslverr = access && s_reg.pslverr;
    assign prdata = s_reg.prdata;
    assign resetOutN = s_reg.resetOut;
    assign hostMode = s_reg.hostMode;

    assign activeVideoFlagOut = s_reg.vidOut.activeVideo;
    assign activeVideoFlagOe = videoDrive;
    assign fieldFlagOut = s_reg.fieldOut;
    assign fieldFlagOe = videoDrive;
    assign linePhaseFlagOut = s_reg.lineOut;
    assign linePhaseFlagOe = videoDrive;
    // The lock-control strap always returns to being driven once reset ends.
    assign lockControlOutOut = s_reg.lockCtrlOut;
    assign lockControlOutOe = !s_reg.strapPhase;
    assign horizontalSyncOut = s_reg.vidOut.hsync;
    assign horizontalSyncOe = videoDrive;
    assign verticalSyncOut = s_reg.vidOut.vsync;
    assign verticalSyncOe = videoDrive;
    assign lumaBusOut = s_reg.vidOut.luma;
    assign lumaBusOe = videoDrive;
    assign chromaBusOut = s_reg.vidOut.chroma;
    assign chromaBusOe = videoDrive;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    AST_AV_FOLLOWS: assert property (
        !s_reg.strapPhase |=> activeVideoFlagOut == $past(vidIn.activeVideo))
        else $error("Active-video flag does not follow the line.");

    AST_AV_HIZ: assert property (
        !s_reg.driveEn |-> !activeVideoFlagOe && !lumaBusOe && !chromaBusOe)
        else $error("Pins driven although the drive strap was low.");

    AST_STRAP_INPUT: assert property (
        s_reg.strapPhase |-> !(activeVideoFlagOe || fieldFlagOe || linePhaseFlagOe
            || lockControlOutOe || horizontalSyncOe || verticalSyncOe))
        else $error("A strap pin is driven during reset.");

    AST_DRIVE_AFTER: assert property (
        $fell(s_reg.strapPhase) && s_reg.driveEn |-> activeVideoFlagOe && fieldFlagOe
            && linePhaseFlagOe && horizontalSyncOe && verticalSyncOe && lumaBusOe && chromaBusOe)
        else $error("Outputs not driven after a high drive strap.");

    AST_STRAP_LATCH: assert property (
        s_reg.strapPhase ##1 !s_reg.strapPhase |-> s_reg.driveEn == $past(s_reg.syncAv[1]))
        else $error("Drive strap not latched at the end of reset.");

    AST_FIELD_ODD: assert property (
        !s_reg.ctrl[VSIS_CTRL_FIELD_LOCK_BIT] |=> fieldFlagOut == $past(vidIn.fieldOdd))
        else $error("Field flag does not show field parity.");

    AST_FIELD_VLOCK: assert property (
        s_reg.ctrl[VSIS_CTRL_FIELD_LOCK_BIT] |=> fieldFlagOut == $past(vidIn.verticalLocked))
        else $error("Field flag does not show vertical lock.");

    AST_LINE_PHASE: assert property (
        !s_reg.ctrl[VSIS_CTRL_LINE_LOCK_BIT] |=> linePhaseFlagOut == $past(vidIn.lineNoninverted))
        else $error("Line flag does not show line phase.");

    AST_LINE_HLOCK: assert property (
        s_reg.ctrl[VSIS_CTRL_LINE_LOCK_BIT]
            |=> linePhaseFlagOut == $past(vidIn.horizontalLocked))
        else $error("Line flag does not show horizontal lock.");

    AST_HOST_MODE: assert property (
        s_reg.strapPhase |=> hostMode == $past({s_reg.syncFld[1], s_reg.syncLine[1],
            s_reg.syncLock[1]}))
        else $error("Host mode not taken from the straps.");

    AST_LOCK_RETURN: assert property (
        $fell(s_reg.strapPhase) |-> lockControlOutOe ##1 lockControlOutOe)
        else $error("Lock-control pin not restored after reset.");

    AST_RESET_OUT: assert property (
        !$past(rst, 1) && !$past(rst, 2) && !$past(rst, 3)
            |-> resetOutN == $past(resetInN, 3))
        else $error("Reset output is not the delayed reset input.");

    AST_RESET_OUT_LOW: assert property (
        !s_reg.syncRst[1] |=> !resetOutN)
        else $error("Reset output high while the reset pin is low.");

    // Once the strap phase is over the drive choice and the host mode stay frozen.
    AST_DRIVE_FROZEN: assert property (
        !s_reg.strapPhase |=> $stable(s_reg.driveEn))
        else $error("Drive choice changed outside the strap phase.");

    AST_MODE_FROZEN: assert property (
        !s_reg.strapPhase |=> $stable(hostMode))
        else $error("Host mode changed outside the strap phase.");

    AST_PHASE_ENTRY: assert property (
        !s_reg.syncRst[1] |=> s_reg.strapPhase)
        else $error("Strap phase not entered while the reset pin is low.");

    AST_DRIVE_HOLD: assert property (
        !s_reg.strapPhase && s_reg.driveEn |-> activeVideoFlagOe && fieldFlagOe
            && linePhaseFlagOe && horizontalSyncOe && verticalSyncOe && lumaBusOe && chromaBusOe)
        else $error("Video pins not driven although the drive strap was high.");

    AST_HIZ_AFTER: assert property (
        !s_reg.strapPhase && !s_reg.driveEn |-> !(activeVideoFlagOe || fieldFlagOe
            || linePhaseFlagOe || horizontalSyncOe || verticalSyncOe || lumaBusOe || chromaBusOe))
        else $error("Video pins driven although the drive strap was low.");

    AST_LOCK_OUT: assert property (
        !s_reg.strapPhase |-> lockControlOutOe ##1 lockControlOutOut == $past(lockControlIn))
        else $error("Lock-control pin does not carry its output value.");

    // The syncs and pixel buses pass through the same single register stage as the flag,
    // so downstream logic sees them aligned with the active-video window.
    AST_SYNC_FOLLOWS: assert property (
        !s_reg.strapPhase |=> horizontalSyncOut == $past(vidIn.hsync)
            && verticalSyncOut == $past(vidIn.vsync))
        else $error("Sync outputs do not follow the line.");

    AST_BUS_FOLLOWS: assert property (
        !s_reg.strapPhase |=> lumaBusOut == $past(vidIn.luma)
            && chromaBusOut == $past(vidIn.chroma))
        else $error("Pixel buses do not follow the line.");

    AST_CTRL_WRITE: assert property (
        psel && penable && pwrite && paddr == VSIS_CTRL_OFS
            |=> s_reg.ctrl == $past(pwdata[1:0]))
        else $error("Control write did not take effect.");

    AST_CTRL_READ: assert property (
        psel && !penable && paddr == VSIS_CTRL_OFS
            |=> prdata == {30'h0000_0000, $past(s_reg.ctrl)})
        else $error("Control read does not return the flag selection.");

    AST_STATUS_READ: assert property (
        psel && !penable && paddr == VSIS_STATUS_OFS
            |=> prdata[VSIS_STAT_MODE_LSB +: 3] == $past(hostMode))
        else $error("Status read does not return the host mode.");

endmodule

// >>> test/vsis_pin_board.sv
`timescale 1ns/1ps
module vsis_pin_board
(
    input wire logic [3:0] strap,
    input wire logic [3:0] pinOut,
    input wire logic [3:0] pinOe,
    output logic [3:0] pinLevel
);
    // Undriven pins show the board pull; each bit, bit 3 included, reads its strap value when open.
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            pinLevel[i] = pinOe[i] ? pinOut[i] : strap[i];
        end
    end
endmodule

// >>> test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import vsis_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    vsis_video_t vidIn = '0;
    logic lockControlIn = 1'b0;
    logic resetInN = 1'b1;
    logic resetOutN;
    logic [3:0] strap = 4'h0;
    logic [3:0] pinOut;
    logic [3:0] pinOe;
    logic [3:0] pinLevel;
    logic hsOut, vsOut, hsOe, vsOe, lumaOe, chromaOe;
    logic [9:0] luma, chroma;
    logic [2:0] hostMode;
    logic [31:0] rd;
    logic err;
    int nErrors = 0;
    int numChecks = 0;

    always #5 clk_sys = ~clk_sys;

    vsis_pin_board board (.strap(strap), .pinOut(pinOut), .pinOe(pinOe), .pinLevel(pinLevel));

    vsis_sync_indicator dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .vidIn(vidIn), .lockControlIn(lockControlIn),
        .resetInN(resetInN), .resetOutN(resetOutN),
        .activeVideoFlagIn(pinLevel[3]), .activeVideoFlagOut(pinOut[3]),
        .activeVideoFlagOe(pinOe[3]), .fieldFlagIn(pinLevel[2]),
        .fieldFlagOut(pinOut[2]), .fieldFlagOe(pinOe[2]), .linePhaseFlagIn(pinLevel[1]),
        .linePhaseFlagOut(pinOut[1]), .linePhaseFlagOe(pinOe[1]),
        .lockControlOutIn(pinLevel[0]), .lockControlOutOut(pinOut[0]),
        .lockControlOutOe(pinOe[0]), .horizontalSyncOut(hsOut), .horizontalSyncOe(hsOe),
        .verticalSyncOut(vsOut), .verticalSyncOe(vsOe), .lumaBusOut(luma),
        .lumaBusOe(lumaOe), .chromaBusOut(chroma), .chromaBusOe(chromaOe),
        .hostMode(hostMode));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp)
        begin
            nErrors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the slave's answer.
        do
        begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // An idle cycle keeps back-to-back calls from driving psel twice in one step.
        @(posedge clk_sys);
    endtask

    task automatic strap_test(input logic [3:0] s);
        strap <= s;
        rst <= 1'b1;
        repeat (4) @(posedge clk_sys);
        check({pinOe, lumaOe, chromaOe, hsOe, vsOe}, 32'h0);
        rst <= 1'b0;
        repeat (5) @(posedge clk_sys);
        check(hostMode, s[2:0]);
        check({pinOe[3:1], hsOe, vsOe, lumaOe, chromaOe}, {7{s[3]}});
        check(pinOe[0], 1'b1);
        apb(1'b0, VSIS_STATUS_OFS, 32'h0);
        check(rd[3:0], {s[2:0], s[3]});
        $display("strap test %h done", s);
    endtask

    task automatic flag_test();
        vsis_video_t v;
        logic f;
        logic l;
        for (int c = 0; c < 4; c++)
        begin
            @(posedge clk_sys);
            apb(1'b1, VSIS_CTRL_OFS, 32'(c));
            apb(1'b0, VSIS_CTRL_OFS, 32'h0);
            check(rd, 32'(c));
            for (int k = 0; k < 8; k++)
            begin
                v = '0;
                v.activeVideo = k[0];
                v.hsync = k[1];
                v.vsync = k[2];
                v.fieldOdd = k[1];
                v.verticalLocked = ~k[1];
                v.lineNoninverted = k[2];
                v.horizontalLocked = ~k[2];
                v.luma = 10'h3A5 ^ 10'(k);
                v.chroma = 10'h05A ^ 10'(k);
                f = c[0] ? v.verticalLocked : v.fieldOdd;
                l = c[1] ? v.horizontalLocked : v.lineNoninverted;
                @(posedge clk_sys);
                vidIn <= v;
                lockControlIn <= k[0];
                @(posedge clk_sys);
                #1;
                check(pinOut[3:1], {k[0], f, l});
                check({pinOut[0], hsOut, vsOut}, {k[0], k[1], k[2]});
                check({luma, chroma}, {v.luma, v.chroma});
            end
        end
        @(posedge clk_sys);
        apb(1'b0, 8'h08, 32'h0);
        check(err, 1'h1);
        check(rd, 32'h0000_0000);
        $display("flag test done");
    endtask

    task automatic reset_out_test();
        @(posedge clk_sys);
        resetInN <= 1'b0;
        strap <= 4'hA;
        repeat (2) @(posedge clk_sys);
        #1;
        check(resetOutN, 1'b1);
        @(posedge clk_sys);
        #1;
        check(resetOutN, 1'b0);
        check(pinOe, 4'h0);
        @(posedge clk_sys);
        resetInN <= 1'b1;
        repeat (6) @(posedge clk_sys);
        check({resetOutN, hostMode, pinOe}, {1'b1, 3'h2, 4'hF});
        $display("reset output test done");
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", numChecks, nErrors);
        if (nErrors == 0 && numChecks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        strap_test(4'h0);
        strap_test(4'h5);
        strap_test(4'hE);
        strap_test(4'hB);
        flag_test();
        reset_out_test();
        complete_run();
    end

    initial
    begin
        #100000;
        nErrors++;
        complete_run();
    end
endmodule
